// [design/arp_timer.sv]
/*
 * 12-bit autoreload timer: four PWM channels with shadowed duty and polarity,
 * output compare flags, shutdown input with fixed pattern, input capture.
 * Assumes a classic Wishbone master, inputs synchronous to clk_i (20 MHz),
 * and low-power mode levels driven by the system controller.
 */
// Our own choices: register access over Wishbone and the address map.
`timescale 1ns/1ps

module arp_timer
    import arp_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    input wire logic shutdown_n_i,
    input wire logic capture_input_pin_i,
    input wire logic lite_tick_i,
    input wire logic fast_tick_i,
    input wire logic slow_mode_i,
    input wire logic wait_i,
    input wire logic halt_i,
    input wire logic active_halt_i,
    output logic [3:0] pwm_o,
    output logic [3:0] pwm_alt_o,
    output logic cmp_cap_irq_o,
    output logic ovf_irq_o,
    output logic wakeup_o
);
    logic [11:0] counter_value;
    logic [11:0] autoreload_value;
    logic [3:0] output_enable_reg;
    logic [11:0] duty_compare_value [ARP_NCH];
    logic [11:0] duty_active [ARP_NCH];
    logic [3:0] output_polarity;
    logic [3:0] polarity_active;
    logic [3:0] pwm_raw;
    logic [3:0] compare_flag;
    logic [3:0] match;
    arp_ctrl_t ctrl;
    arp_sdc_t sdc;
    logic shutdown_active;
    logic shutdown_sampled;
    logic transfer_enable;
    logic overflow_flag;
    logic capture_flag;
    logic [11:0] capture_value_reg;
    logic capture_last;
    logic capture_armed;
    logic capture_edge;
    logic [4:0] slow_div;
    logic slow_pulse;
    logic tick_src;
    logic run;
    logic tick;
    logic ovf;
    logic acc;
    logic wr;
    logic rd;
    logic [31:0] rd_data;

    function automatic logic [11:0] merge12(input logic [11:0] old, input logic [31:0] d, input logic [3:0] s);
        merge12 = {s[1] ? d[11:8] : old[11:8], s[0] ? d[7:0] : old[7:0]};
    endfunction : merge12

    // Wishbone slave: answer one cycle after the request, act on the acked edge
    assign acc = cyc_i & stb_i & ack_o;
    assign wr = acc & we_i;
    assign rd = acc & ~we_i;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
        end else begin
            ack_o <= cyc_i & stb_i & ~ack_o;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_o <= 32'h0000_0000;
        end else if (cyc_i & stb_i & ~ack_o) begin
            dat_o <= rd_data;
        end
    end

    always_comb begin
        rd_data = 32'h0000_0000;
        if (adr_i == ARP_OFS_CSR) begin
            rd_data[ARP_CSR_ICF] = capture_flag;
            rd_data[ARP_CSR_CAPTURE_IRQ_ENABLE] = ctrl.capture_irq_enable;
            rd_data[ARP_CSR_CK +: 2] = ctrl.ck;
            rd_data[ARP_CSR_OVF] = overflow_flag;
            rd_data[ARP_CSR_OVERFLOW_IRQ_ENABLE] = ctrl.overflow_irq_enable;
            rd_data[ARP_CSR_COMPARE_IRQ_ENABLE] = ctrl.compare_irq_enable;
        end else if (adr_i == ARP_OFS_CNT) begin
            rd_data[11:0] = counter_value;
        end else if (adr_i == ARP_OFS_ARR) begin
            rd_data[11:0] = autoreload_value;
        end else if (adr_i == ARP_OFS_OE) begin
            rd_data[3:0] = output_enable_reg;
        end else if (adr_i[7:4] == ARP_OFS_STAT[7:4]) begin
            rd_data[ARP_STAT_COMPARE_FLAG] = compare_flag[adr_i[3:2]];
            rd_data[ARP_STAT_POL] = output_polarity[adr_i[3:2]];
        end else if (adr_i[7:4] == ARP_OFS_DUTY[7:4]) begin
            rd_data[11:0] = duty_compare_value[adr_i[3:2]];
        end else if (adr_i == ARP_OFS_SDC) begin
            rd_data[ARP_SDC_PAT +: 4] = sdc.pattern;
            rd_data[ARP_SDC_PEN] = sdc.pen;
            rd_data[ARP_SDC_ACT] = shutdown_active;
        end else if (adr_i == ARP_OFS_ICR) begin
            rd_data[11:0] = capture_value_reg;
        end else if (adr_i == ARP_OFS_TRAN) begin
            rd_data[0] = transfer_enable;
        end
    end

    // Counter clock: selection, slow-mode divider and power-mode gating
    assign slow_pulse = (slow_div == ARP_SLOW_LAST);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            slow_div <= 5'h00;
        end else begin
            slow_div <= slow_div + 5'h01;
        end
    end

    always_comb begin
        case (ctrl.ck)
            ARP_CK_OFF: tick_src = 1'b0;
            ARP_CK_LITE: tick_src = lite_tick_i;
            ARP_CK_CPU: tick_src = slow_mode_i ? slow_pulse : 1'b1;
            ARP_CK_FAST: tick_src = fast_tick_i;
            default: tick_src = 1'b0;
        endcase
    end

    // Wait leaves the timer running; halt always stops it
    assign run = ~halt_i & ~(active_halt_i & ~(ctrl.ck == ARP_CK_LITE && ctrl.overflow_irq_enable));
    assign tick = tick_src & run & ~shutdown_active;
    assign ovf = tick & (counter_value == ARP_CNT_MAX);

    always_ff @(posedge clk_i) begin
        if (rst_i || shutdown_active) begin
            counter_value <= ARP_CNT_RST;
        end else if (ovf) begin
            counter_value <= autoreload_value;
        end else if (tick) begin
            counter_value <= counter_value + 12'h001;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i || shutdown_active) begin
            autoreload_value <= 12'h000;
        end else if (wr && adr_i == ARP_OFS_ARR) begin
            autoreload_value <= merge12(autoreload_value, dat_i, sel_i);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i || shutdown_active) begin
            output_enable_reg <= 4'h0;
        end else if (wr && adr_i == ARP_OFS_OE && sel_i[0]) begin
            output_enable_reg <= dat_i[3:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl <= '0;
        end else if (wr && adr_i == ARP_OFS_CSR && sel_i[0]) begin
            ctrl.capture_irq_enable <= dat_i[ARP_CSR_CAPTURE_IRQ_ENABLE];
            ctrl.ck <= arp_ck_t'(dat_i[ARP_CSR_CK +: 2]);
            ctrl.overflow_irq_enable <= dat_i[ARP_CSR_OVERFLOW_IRQ_ENABLE];
            ctrl.compare_irq_enable <= dat_i[ARP_CSR_COMPARE_IRQ_ENABLE];
        end
    end

    // Hardware set wins over the read that clears
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            overflow_flag <= 1'b0;
        end else if (ovf) begin
            overflow_flag <= 1'b1;
        end else if (rd && adr_i == ARP_OFS_CSR) begin
            overflow_flag <= 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            transfer_enable <= ARP_TRAN_RST;
        end else if (wr && adr_i == ARP_OFS_TRAN && sel_i[0]) begin
            transfer_enable <= dat_i[0];
        end else if (ovf) begin
            transfer_enable <= 1'b0;
        end
    end

    // Per-channel duty, polarity, PWM level and compare flag
    for (genvar i = 0; i < ARP_NCH; i++) begin : g_ch
        localparam logic [7:0] OFS_ST = ARP_OFS_STAT + 8'(i * 4);
        localparam logic [7:0] OFS_DU = ARP_OFS_DUTY + 8'(i * 4);

        // Fires on the edge at which the counter reaches the duty value, so the output is low while it is shown
        assign match[i] = tick & (counter_value != ARP_CNT_MAX) & ((counter_value + 12'h001) == duty_active[i]);

        always_ff @(posedge clk_i) begin
            if (rst_i || shutdown_active) begin
                duty_compare_value[i] <= 12'h000;
            end else if (wr && adr_i == OFS_DU) begin
                duty_compare_value[i] <= merge12(duty_compare_value[i], dat_i, sel_i);
            end
        end

        always_ff @(posedge clk_i) begin
            if (rst_i || shutdown_active) begin
                duty_active[i] <= 12'h000;
            end else if (ovf && transfer_enable) begin
                duty_active[i] <= duty_compare_value[i];
            end
        end

        always_ff @(posedge clk_i) begin
            if (rst_i) begin
                output_polarity[i] <= 1'b0;
            end else if (wr && adr_i == OFS_ST && sel_i[0]) begin
                output_polarity[i] <= dat_i[ARP_STAT_POL];
            end
        end

        // Without transfer enable the inversion follows the bit at once
        always_ff @(posedge clk_i) begin
            if (rst_i) begin
                polarity_active[i] <= 1'b0;
            end else if (!transfer_enable || ovf) begin
                polarity_active[i] <= output_polarity[i];
            end
        end

        always_ff @(posedge clk_i) begin
            if (rst_i || shutdown_active) begin
                pwm_raw[i] <= ARP_PWM_RST;
            end else if (ovf) begin
                pwm_raw[i] <= 1'b1;
            end else if (match[i]) begin
                pwm_raw[i] <= 1'b0;
            end
        end

        always_ff @(posedge clk_i) begin
            if (rst_i) begin
                compare_flag[i] <= 1'b0;
            end else if (match[i] && duty_active[i] != 12'h000) begin
                compare_flag[i] <= 1'b1;
            end else if (rd && adr_i == OFS_ST) begin
                compare_flag[i] <= 1'b0;
            end
        end

        always_ff @(posedge clk_i) begin
            if (rst_i) begin
                pwm_o[i] <= 1'b0;
                pwm_alt_o[i] <= 1'b0;
            end else begin
                // Pattern goes after the inverter so the safe state is absolute
                pwm_o[i] <= shutdown_active ? sdc.pattern[i] :
                    (output_enable_reg[i] & (pwm_raw[i] ^ polarity_active[i]));
                pwm_alt_o[i] <= shutdown_active | output_enable_reg[i];
            end
        end
    end

    // Shutdown control
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            shutdown_sampled <= 1'b1;
        end else begin
            shutdown_sampled <= shutdown_n_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sdc <= '0;
        end else if (wr && adr_i == ARP_OFS_SDC && sel_i[0]) begin
            sdc.pen <= dat_i[ARP_SDC_PEN];
            sdc.pattern <= dat_i[ARP_SDC_PAT +: 4];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            shutdown_active <= 1'b0;
        end else if (sdc.pen && !shutdown_sampled) begin
            shutdown_active <= 1'b1;
        end else if (wr && adr_i == ARP_OFS_SDC && sel_i[0]) begin
            shutdown_active <= dat_i[ARP_SDC_ACT];
        end
    end

    // Input capture; the first cycle after reset sees no edge
    assign capture_edge = capture_armed & (capture_input_pin_i ^ capture_last);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            capture_last <= 1'b0;
            capture_armed <= 1'b0;
        end else begin
            capture_last <= capture_input_pin_i;
            capture_armed <= 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            capture_value_reg <= 12'h000;
        end else if (capture_edge && !capture_flag) begin
            capture_value_reg <= counter_value;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            capture_flag <= 1'b0;
        end else if (capture_edge && !capture_flag) begin
            capture_flag <= 1'b1;
        end else if (rd && adr_i == ARP_OFS_ICR) begin
            capture_flag <= 1'b0;
        end
    end

    // Interrupt requests and wake-up
    assign cmp_cap_irq_o = ((|compare_flag) & ctrl.compare_irq_enable) | (capture_flag & ctrl.capture_irq_enable);
    assign ovf_irq_o = overflow_flag & ctrl.overflow_irq_enable;
    assign wakeup_o = (wait_i & (cmp_cap_irq_o | ovf_irq_o))
        | (active_halt_i & ovf_irq_o & (ctrl.ck == ARP_CK_LITE));

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    property p_cnt_inc;
        (tick && counter_value != ARP_CNT_MAX) |=> shutdown_active || counter_value == $past(counter_value) + 12'h001;
    endproperty
    a_cnt_inc: assert property (p_cnt_inc) else $error("counter did not increment");

    property p_reload;
        ovf |=> overflow_flag && (shutdown_active || counter_value == $past(autoreload_value));
    endproperty
    a_reload: assert property (p_reload) else $error("overflow did not reload or flag");

    property p_xfer;
        (ovf && transfer_enable && !(wr && adr_i == ARP_OFS_TRAN)) |=>
            !transfer_enable && pwm_raw[0] && (shutdown_active || duty_active[0] == $past(duty_compare_value[0]));
    endproperty
    a_xfer: assert property (p_xfer) else $error("shadow transfer wrong");

    sequence s_fall;
        match[0] && !ovf && duty_active[0] != 12'h000;
    endsequence
    property p_fall;
        s_fall |=> compare_flag[0] && (shutdown_active || !pwm_raw[0]);
    endproperty
    a_fall: assert property (p_fall) else $error("match did not drop output with flag");

    property p_cmp_zero;
        $rose(compare_flag[0]) |-> $past(duty_active[0]) != 12'h000;
    endproperty
    a_cmp_zero: assert property (p_cmp_zero) else $error("compare flag from zero value");

    property p_sd_pin;
        (sdc.pen && !shutdown_sampled) |=> shutdown_active ##1 (counter_value == ARP_CNT_RST
            && autoreload_value == 12'h000 && output_enable_reg == 4'h0);
    endproperty
    a_sd_pin: assert property (p_sd_pin) else $error("shutdown pin not honoured");

    property p_sd_pattern;
        shutdown_active |=> pwm_o == $past(sdc.pattern) && pwm_alt_o == 4'hF;
    endproperty
    a_sd_pattern: assert property (p_sd_pattern) else $error("shutdown pattern not driven");

    property p_cap;
        (capture_edge && !capture_flag) |=> capture_flag && capture_value_reg == $past(counter_value);
    endproperty
    a_cap: assert property (p_cap) else $error("capture not latched");

    property p_cap_hold;
        (capture_flag && !(rd && adr_i == ARP_OFS_ICR)) |=> capture_flag && $stable(capture_value_reg);
    endproperty
    a_cap_hold: assert property (p_cap_hold) else $error("capture changed while flag set");

    property p_halt;
        halt_i |=> $stable(counter_value) || $past(shutdown_active);
    endproperty
    a_halt: assert property (p_halt) else $error("counter moved in halt");
endmodule : arp_timer

// [design/arp_pkg.sv]
/*
 * Shared constants and types for the 12-bit autoreload PWM / capture timer.
 * Assumes a classic Wishbone slave with 32-bit data and byte addressing.
 */
package arp_pkg;
    localparam int ARP_CW = 12;
    localparam int ARP_NCH = 4;
    localparam logic [11:0] ARP_CNT_MAX = 12'hFFF;
    localparam logic [11:0] ARP_CNT_RST = 12'h000;
    localparam logic [4:0] ARP_SLOW_LAST = 5'h1F;

    // Register byte offsets
    localparam logic [7:0] ARP_OFS_CSR = 8'h00;
    localparam logic [7:0] ARP_OFS_CNT = 8'h04;
    localparam logic [7:0] ARP_OFS_ARR = 8'h08;
    localparam logic [7:0] ARP_OFS_OE = 8'h0C;
    localparam logic [7:0] ARP_OFS_STAT = 8'h10;
    localparam logic [7:0] ARP_OFS_DUTY = 8'h20;
    localparam logic [7:0] ARP_OFS_SDC = 8'h30;
    localparam logic [7:0] ARP_OFS_ICR = 8'h34;
    localparam logic [7:0] ARP_OFS_TRAN = 8'h38;

    // Control/status field positions
    localparam int ARP_CSR_COMPARE_IRQ_ENABLE = 0;
    localparam int ARP_CSR_OVERFLOW_IRQ_ENABLE = 1;
    localparam int ARP_CSR_OVF = 2;
    localparam int ARP_CSR_CK = 3;
    localparam int ARP_CSR_CAPTURE_IRQ_ENABLE = 5;
    localparam int ARP_CSR_ICF = 6;
    localparam int ARP_STAT_COMPARE_FLAG = 0;
    localparam int ARP_STAT_POL = 1;
    localparam int ARP_SDC_PAT = 0;
    localparam int ARP_SDC_PEN = 4;
    localparam int ARP_SDC_ACT = 5;

    // Reset values
    localparam logic ARP_TRAN_RST = 1'b1;
    localparam logic ARP_PWM_RST = 1'b1;

    typedef enum logic [1:0] {
        ARP_CK_OFF,
        ARP_CK_LITE,
        ARP_CK_CPU,
        ARP_CK_FAST
    } arp_ck_t;

    typedef struct packed {
        logic capture_irq_enable;
        arp_ck_t ck;
        logic overflow_irq_enable;
        logic compare_irq_enable;
    } arp_ctrl_t;

    typedef struct packed {
        logic pen;
        logic [3:0] pattern;
    } arp_sdc_t;
endpackage : arp_pkg

// [tb/arp_pwr_stage.sv]
/*
 * Power stage model at the far side of the timer: measures high time and
 * period of PWM channel 0, drives the active-low shutdown pin and the capture
 * source. Assumes all lines are registered on the same 20 MHz clock.
 */
`timescale 1ns/1ps
module arp_pwr_stage (
    input wire logic clk_i,
    input wire logic pwm_i,
    input wire logic trip_i,
    input wire logic flip_i,
    output logic shutdown_n_o,
    output logic cap_o,
    output logic meas_o,
    output logic [15:0] hi_o,
    output logic [15:0] per_o
);
    logic prev = 1'b0;
    logic seen = 1'b0;
    logic [15:0] cnt = 16'h0000;
    initial begin
        shutdown_n_o = 1'b1;
        cap_o = 1'b0;
        meas_o = 1'b0;
        hi_o = 16'h0000;
        per_o = 16'h0000;
    end
    always @(posedge clk_i) begin
        // Pin is low only for the cycles the bench requests
        shutdown_n_o <= !trip_i;
        if (flip_i) begin
            cap_o <= !cap_o;
        end
        prev <= pwm_i;
        meas_o <= 1'b0;
        cnt <= cnt + 16'h0001;
        // Period runs rising edge to rising edge; the first edge only arms it
        if (pwm_i && !prev) begin
            if (seen) begin
                per_o <= cnt;
                meas_o <= 1'b1;
            end
            seen <= 1'b1;
            cnt <= 16'h0001;
        end
        if (!pwm_i && prev) begin
            hi_o <= cnt;
        end
    end
endmodule : arp_pwr_stage

// [tb/tb.sv]
/*
 * Self-checking bench for the autoreload PWM / capture timer.
 * Assumes the power stage model on channel 0 and a Wishbone master here.
 */
`timescale 1ns/1ps
module tb;
    import arp_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc_i = 1'b0;
    logic stb_i = 1'b0;
    logic we_i = 1'b0;
    logic [7:0] adr_i = 8'h00;
    logic [3:0] sel_i = 4'h0;
    logic [31:0] dat_i = 32'h0;
    logic wait_i = 1'b0;
    logic halt_i = 1'b0;
    logic trip = 1'b0;
    logic flip = 1'b0;
    logic [31:0] dat_o;
    logic ack_o, shutdown_n, cap, meas, cmp_cap_irq_o, ovf_irq_o, wakeup_o;
    logic [15:0] hi, per, w;
    logic [3:0] pwm_o, pwm_alt_o, pat;
    logic [15:0] lfsr = 16'hDD22;
    logic [63:0] rd_q[$];
    logic [31:0] pw_q[$];
    int err_total = 0;
    int n_tests = 0;
    int i, k;
    always #25 clk_i = !clk_i;

    arp_timer u_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
        .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
        .shutdown_n_i(shutdown_n), .capture_input_pin_i(cap), .lite_tick_i(1'b0),
        .fast_tick_i(1'b0), .slow_mode_i(1'b0), .wait_i(wait_i), .halt_i(halt_i),
        .active_halt_i(1'b0), .pwm_o(pwm_o), .pwm_alt_o(pwm_alt_o),
        .cmp_cap_irq_o(cmp_cap_irq_o), .ovf_irq_o(ovf_irq_o), .wakeup_o(wakeup_o));
    arp_pwr_stage u_stage (.clk_i(clk_i), .pwm_i(pwm_o[0]), .trip_i(trip), .flip_i(flip),
        .shutdown_n_o(shutdown_n), .cap_o(cap), .meas_o(meas), .hi_o(hi), .per_o(per));

    function automatic logic [15:0] lfsr_next(input logic [15:0] v);
        return v[0] ? ((v >> 1) ^ 16'hB400) : (v >> 1);
    endfunction : lfsr_next
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : close_out
    task automatic fail();
        err_total++;
        close_out();
    endtask : fail
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int j;
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= wr;
        adr_i <= a;
        dat_i <= d;
        sel_i <= 4'hF;
        for (j = 0; j < 20; j++) begin
            @(posedge clk_i);
            if (ack_o === 1'b1) break;
        end
        if (j == 20) fail();
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i <= 1'b0;
    endtask : bus
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
        rd_q.push_back({m, e});
        bus(1'b0, a, 32'h0);
    endtask : rd
    // Waits for the ovf request under a bound; 4096 counts cover the first wrap
    task automatic wait_ovf();
        for (i = 0; i < 5000 && ovf_irq_o !== 1'b1; i++) @(posedge clk_i);
        if (i == 5000) fail();
    endtask : wait_ovf

    // Results are checked in arrival order against notes left by the driver
    always @(posedge clk_i) begin : mon
        logic [63:0] r;
        logic [31:0] p;
        if (ack_o === 1'b1 && !we_i && rd_q.size() > 0) begin
            r = rd_q.pop_front();
            cmp(dat_o & r[63:32], r[31:0]);
        end
        if (meas === 1'b1 && pw_q.size() > 0) begin
            p = pw_q.pop_front();
            cmp({hi, per}, p);
        end
    end

    initial begin
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(ARP_OFS_CNT, 32'h0, 32'hFFF);
        rd(ARP_OFS_TRAN, 32'h1, 32'hFF);
        rd(8'hFC, 32'h0, 32'hFFFFFFFF);
        $display("end reset test");
        // Reload FF0 gives a 16-cycle period so each check needs few cycles
        bus(1'b1, ARP_OFS_ARR, 32'h0FF0);
        bus(1'b1, ARP_OFS_OE, 32'hF);
        bus(1'b1, ARP_OFS_CSR, 32'h12);
        wait_ovf();
        for (k = 0; k < 4; k++) begin
            lfsr = lfsr_next(lfsr);
            w = 16'h0001 + {13'h0, lfsr[2:0]};
            bus(1'b1, ARP_OFS_DUTY, {20'h0, 12'hFF0 + w[11:0]});
            bus(1'b1, ARP_OFS_STAT, {30'h0, k[0], 1'b0});
            bus(1'b1, ARP_OFS_TRAN, 32'h1);
            repeat (48) @(posedge clk_i);
            pw_q.push_back({k[0] ? 16'h0010 - w : w, 16'h0010});
            for (i = 0; i < 200 && pw_q.size() > 0; i++) @(posedge clk_i);
            if (pw_q.size() > 0) fail();
        end
        rd(ARP_OFS_TRAN, 32'h0, 32'h1);
        rd(ARP_OFS_STAT + 8'h08, 32'h0, 32'h1);
        $display("end pwm test");
        bus(1'b1, ARP_OFS_CSR, 32'h32);
        @(posedge clk_i);
        flip <= 1'b1;
        @(posedge clk_i);
        flip <= 1'b0;
        repeat (4) @(negedge clk_i);
        cmp({31'h0, cmp_cap_irq_o}, 32'h1);
        rd(ARP_OFS_ICR, 32'hFF0, 32'hFF0);
        rd(ARP_OFS_CSR, 32'h0, 32'h40);
        bus(1'b1, ARP_OFS_CSR, 32'h72);
        rd(ARP_OFS_CSR, 32'h0, 32'h40);
        $display("end capture test");
        halt_i <= 1'b1;
        rd(ARP_OFS_CSR, 32'h0, 32'h40);
        repeat (40) @(posedge clk_i);
        rd(ARP_OFS_CSR, 32'h0, 32'h4);
        rd(ARP_OFS_STAT, 32'h1, 32'h1);
        rd(ARP_OFS_STAT, 32'h0, 32'h1);
        halt_i <= 1'b0;
        wait_i <= 1'b1;
        wait_ovf();
        @(negedge clk_i);
        cmp({31'h0, wakeup_o}, 32'h1);
        wait_i <= 1'b0;
        $display("end low power test");
        lfsr = lfsr_next(lfsr);
        pat = lfsr[3:0];
        bus(1'b1, ARP_OFS_SDC, {26'h0, 2'b01, pat});
        @(posedge clk_i);
        trip <= 1'b1;
        @(posedge clk_i);
        trip <= 1'b0;
        repeat (5) @(negedge clk_i);
        cmp({24'h0, pwm_alt_o, pwm_o}, {24'h0, 4'hF, pat});
        rd(ARP_OFS_SDC, {26'h0, 2'b11, pat}, 32'h3F);
        rd(ARP_OFS_ARR, 32'h0, 32'hFFF);
        rd(ARP_OFS_OE, 32'h0, 32'hF);
        rd(ARP_OFS_CNT, 32'h0, 32'hFFF);
        bus(1'b1, ARP_OFS_SDC, {26'h0, 2'b00, pat});
        repeat (3) @(negedge clk_i);
        cmp({28'h0, pwm_alt_o}, 32'h0);
        bus(1'b1, ARP_OFS_SDC, {26'h0, 2'b10, pat});
        repeat (3) @(negedge clk_i);
        cmp({24'h0, pwm_alt_o, pwm_o}, {24'h0, 4'hF, pat});
        $display("end shutdown test");
        close_out();
    end
endmodule : tb
